/* File: shared/osecc_pkg.sv */
package osecc_pkg;

    // ****************************************************************
    // sector geometry, element positions counted from one
    // ****************************************************************
    localparam logic [11:0] LG_DATA_END = 12'd2048;
    localparam logic [11:0] LG_FILL_END = 12'd2056;
    localparam logic [11:0] LG_CHK_END = 12'd2060;
    localparam logic [11:0] LG_TOTAL = 12'd2380;
    localparam logic [4:0] LG_COLS = 5'd20;
    localparam logic [5:0] LG_RS_PERIOD = 6'd60;
    localparam logic [5:0] LG_RS_MAX = 6'd39;
    localparam logic [11:0] SM_DATA_END = 12'd512;
    localparam logic [11:0] SM_FILL_END = 12'd516;
    localparam logic [11:0] SM_CHK_END = 12'd520;
    localparam logic [11:0] SM_TOTAL = 12'd600;
    localparam logic [4:0] SM_COLS = 5'd5;
    localparam logic [5:0] SM_RS_PERIOD = 6'd20;
    localparam logic [5:0] SM_RS_MAX = 6'd29;
    localparam int MAX_COLS = 20;
    localparam int CHECK_BYTES = 4;
    localparam int ECC_BYTES = 16;
    localparam int FIFO_DEPTH = 4;

    // ****************************************************************
    // field arithmetic and generator constants
    // ****************************************************************
    localparam logic [7:0] FILL_BYTE = 8'hff;
    localparam logic [7:0] GF_POLY_LOW = 8'h2d;
    localparam int ALPHA_EXP = 88;
    localparam int CRC_FIRST_ROOT = 136;
    localparam int ECC_FIRST_ROOT = 120;
    localparam logic [15:0] ID_POLY = 16'h1021;
    localparam logic [23:0] ID_INV_MASK = 24'hff_ff00;
    localparam logic [23:0] RESYNC_BASE = 24'h10_1020;
    localparam logic [23:0] RESYNC_ALT = 24'h10_1028;
    localparam int RESYNC_X_BIT = 22;
    localparam int RESYNC_Y_BIT = 0;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        KIND_SYNC = 3'd0,
        KIND_DATA = 3'd1,
        KIND_FILL = 3'd2,
        KIND_CHECK = 3'd3,
        KIND_ECC = 3'd4,
        KIND_RESYNC = 3'd5
    } osecc_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BODY = 2'b10
    } osecc_fsm_t;

    typedef struct packed {
        osecc_kind_t kind;
        logic [7:0] data;
        logic [23:0] pattern;
    } osecc_elem_t;

    typedef struct packed {
        osecc_fsm_t fsm;
        logic is_small;
        logic ov;
        osecc_elem_t elem;
        logic [11:0] n;
        logic [4:0] col;
        logic [3:0] t;
        logic [7:0] rowsum;
        logic [3:0][7:0] crc;
        logic [MAX_COLS-1:0][15:0][7:0] ecc;
        logic rs_pend;
        logic [5:0] rsph;
        logic [5:0] rscnt;
        logic id_ok;
        logic [15:0] id_crc;
    } osecc_state_t;

    // ****************************************************************
    // functions
    // ****************************************************************
    function automatic logic [7:0] osecc_gf_mul(input logic [7:0] a,
                                                input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                p = p ^ x;
            end
            x = {x[6:0], 1'b0} ^ (x[7] ? GF_POLY_LOW : 8'h00);
        end
        return p;
    endfunction

    function automatic logic [7:0] osecc_beta_pow(input int e);
        logic [7:0] r;
        r = 8'h01;
        for (int i = 0; i < 255; i++) begin
            if (i < e) begin
                r = osecc_gf_mul(r, 8'h02);
            end
        end
        return r;
    endfunction

    // monic generator, low coefficients only
    function automatic logic [15:0][7:0] osecc_gen_poly(input int first,
                                                        input int cnt);
        logic [16:0][7:0] g;
        logic [7:0] root;
        g = '0;
        g[0] = 8'h01;
        for (int i = 0; i < cnt; i++) begin
            root = osecc_beta_pow((ALPHA_EXP * (first + i)) % 255);
            for (int k = 16; k > 0; k--) begin
                g[k] = g[k-1] ^ osecc_gf_mul(root, g[k]);
            end
            g[0] = osecc_gf_mul(root, g[0]);
        end
        return g[15:0];
    endfunction

    // one division step, highest degree in entry deg-1
    function automatic logic [15:0][7:0] osecc_rs_step(
        input logic [15:0][7:0] r, input logic [7:0] d,
        input logic [15:0][7:0] g, input int deg);
        logic [15:0][7:0] q;
        logic [7:0] fb;
        q = '0;
        fb = d ^ r[deg-1];
        for (int k = 0; k < 16; k++) begin
            if (k < deg) begin
                q[k] = ((k > 0) ? r[k-1] : 8'h00) ^ osecc_gf_mul(fb, g[k]);
            end
        end
        return q;
    endfunction

    function automatic logic [15:0] osecc_id_crc(input logic [23:0] b);
        logic [23:0] m;
        logic [15:0] r;
        logic fb;
        m = b ^ ID_INV_MASK;
        r = 16'h0000;
        for (int i = 23; i >= 0; i--) begin
            fb = m[i] ^ r[15];
            r = {r[14:0], 1'b0} ^ (fb ? ID_POLY : 16'h0000);
        end
        return r;
    endfunction

endpackage

/* File: src/osecc_enc.sv */
`timescale 1ns/1ps

// ********************************************************************
// byte fifo
// ********************************************************************
module osecc_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [W-1:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [W-1:0] rd_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = AW'(DEPTH) == '0 ?
        (AW+1)'(DEPTH) : (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
    } osecc_fifo_st_t;

    osecc_fifo_st_t f_r;
    osecc_fifo_st_t f_nxt;
    logic push;
    logic pop;

    // handshake and head word
    assign wr_ready = (f_r.cnt != FULL_CNT);
    assign rd_valid = (f_r.cnt != '0);
    assign rd_data = f_r.mem[f_r.rd];
    assign push = wr_valid && wr_ready;
    assign pop = rd_valid && rd_ready;

    // pointer and count update
    always_comb begin
        f_nxt = f_r;
        if (push) begin
            f_nxt.mem[f_r.wr] = wr_data;
            f_nxt.wr = (f_r.wr == AW'(DEPTH - 1)) ? '0 : f_r.wr + 1'b1;
        end
        if (pop) begin
            f_nxt.rd = (f_r.rd == AW'(DEPTH - 1)) ? '0 : f_r.rd + 1'b1;
        end
        if (push && !pop) begin
            f_nxt.cnt = f_r.cnt + 1'b1;
        end else if (pop && !push) begin
            f_nxt.cnt = f_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            f_r <= '0;
        end else begin
            f_r <= f_nxt;
        end
    end
endmodule

// ********************************************************************
// sector encoder
// ********************************************************************
module osecc_enc #(
    parameter int FIFO_W = 8,
    parameter int FIFO_D = osecc_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic mode_small,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output osecc_pkg::osecc_elem_t out_elem,
    input wire logic resync_alt,
    input wire logic chan_prev_bit,
    input wire logic chan_next_bit,
    input wire logic id_valid,
    input wire logic [23:0] id_bytes,
    output logic id_crc_valid,
    output logic [15:0] id_crc
);
    import osecc_pkg::*;

    localparam logic [15:0][7:0] CRC_GEN =
        osecc_gen_poly(CRC_FIRST_ROOT, CHECK_BYTES);
    localparam logic [15:0][7:0] ECC_GEN =
        osecc_gen_poly(ECC_FIRST_ROOT, ECC_BYTES);

    osecc_state_t st_r;
    osecc_state_t st_nxt;
    logic fifo_valid;
    logic fifo_pop;
    logic [7:0] fifo_data;
    logic take;
    logic have;
    logic [11:0] nn;
    logic [7:0] byte_v;
    logic [7:0] rowin;
    logic [15:0][7:0] crc_tmp;
    logic [11:0] data_end;
    logic [11:0] fill_end;
    logic [11:0] chk_end;
    logic [11:0] total;
    logic [4:0] cols;
    logic [5:0] period;
    logic [5:0] rs_max;

    // ****************************************************************
    // input buffer, back-pressure reaches in_ready
    // ****************************************************************
    osecc_fifo #(
        .W(FIFO_W),
        .DEPTH(FIFO_D)
    ) i_osecc_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .wr_valid(in_valid),
        .wr_ready(in_ready),
        .wr_data(in_data),
        .rd_valid(fifo_valid),
        .rd_ready(fifo_pop),
        .rd_data(fifo_data)
    );

    // outputs straight from state flops
    assign out_valid = st_r.ov;
    assign out_elem = st_r.elem;
    assign id_crc_valid = st_r.id_ok;
    assign id_crc = st_r.id_crc;
    assign take = !st_r.ov || out_ready;

    // ****************************************************************
    // element sequencer
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        fifo_pop = 1'b0;
        have = 1'b0;
        byte_v = 8'h00;
        rowin = 8'h00;
        crc_tmp = '0;
        nn = st_r.n + 12'd1;
        // mode limits, mode latched at sector start
        data_end = st_r.is_small ? SM_DATA_END : LG_DATA_END;
        fill_end = st_r.is_small ? SM_FILL_END : LG_FILL_END;
        chk_end = st_r.is_small ? SM_CHK_END : LG_CHK_END;
        total = st_r.is_small ? SM_TOTAL : LG_TOTAL;
        cols = st_r.is_small ? SM_COLS : LG_COLS;
        period = st_r.is_small ? SM_RS_PERIOD : LG_RS_PERIOD;
        rs_max = st_r.is_small ? SM_RS_MAX : LG_RS_MAX;
        // header id check, one cycle after the request
        st_nxt.id_ok = id_valid;
        if (id_valid) begin
            st_nxt.id_crc = osecc_id_crc(id_bytes);
        end
        if (take) begin
            st_nxt.ov = 1'b0;
        end
        case (st_r.fsm)
            ST_IDLE: begin
                if (take && fifo_valid) begin
                    st_nxt.is_small = mode_small;
                    st_nxt.ov = 1'b1;
                    st_nxt.elem = '{KIND_SYNC, 8'h00, 24'h00_0000};
                    st_nxt.n = '0;
                    st_nxt.col = '0;
                    st_nxt.t = '0;
                    st_nxt.rowsum = '0;
                    st_nxt.crc = '0;
                    st_nxt.ecc = '0;
                    st_nxt.rs_pend = 1'b0;
                    st_nxt.rsph = '0;
                    st_nxt.rscnt = '0;
                    st_nxt.fsm = ST_BODY;
                end
            end
            ST_BODY: begin
                if (take && st_r.rs_pend) begin
                    // resync element, input stalls meanwhile
                    st_nxt.rs_pend = 1'b0;
                    st_nxt.ov = 1'b1;
                    st_nxt.elem.kind = KIND_RESYNC;
                    st_nxt.elem.data = 8'h00;
                    st_nxt.elem.pattern = resync_alt ? RESYNC_ALT
                                                     : RESYNC_BASE;
                    st_nxt.elem.pattern[RESYNC_X_BIT] = !chan_prev_bit;
                    st_nxt.elem.pattern[RESYNC_Y_BIT] = !chan_next_bit;
                end else if (take) begin
                    if (nn <= data_end) begin
                        have = fifo_valid;
                        fifo_pop = fifo_valid;
                        byte_v = fifo_data;
                        st_nxt.elem.kind = KIND_DATA;
                    end else if (nn <= fill_end) begin
                        have = 1'b1;
                        byte_v = FILL_BYTE;
                        st_nxt.elem.kind = KIND_FILL;
                    end else if (nn <= chk_end) begin
                        // c1 first, shifted out highest degree first
                        have = 1'b1;
                        byte_v = st_r.crc[3];
                        st_nxt.crc = {st_r.crc[2:0], 8'h00};
                        st_nxt.elem.kind = KIND_CHECK;
                    end else begin
                        // e(s,t): column fastest, t=1 highest degree
                        have = 1'b1;
                        byte_v = ~st_r.ecc[st_r.col][4'd15 - st_r.t];
                        st_nxt.elem.kind = KIND_ECC;
                    end
                    if (have) begin
                        st_nxt.n = nn;
                        st_nxt.ov = 1'b1;
                        st_nxt.elem.data = byte_v;
                        st_nxt.elem.pattern = '0;
                        if (nn <= chk_end) begin
                            // column codeword update, rows come high to low
                            st_nxt.ecc[st_r.col] = osecc_rs_step(
                                st_r.ecc[st_r.col], byte_v, ECC_GEN,
                                ECC_BYTES);
                        end
                        if (nn <= fill_end) begin
                            rowin = st_r.rowsum ^ byte_v;
                            st_nxt.rowsum = rowin;
                            // row end, row 0 ends early before the checks
                            if (nn == fill_end || st_r.col == cols - 5'd1) begin
                                crc_tmp = osecc_rs_step({96'h0, st_r.crc},
                                    rowin, CRC_GEN, CHECK_BYTES);
                                st_nxt.crc = crc_tmp[3:0];
                                st_nxt.rowsum = '0;
                            end
                        end
                        if (st_r.col == cols - 5'd1) begin
                            st_nxt.col = '0;
                            if (nn > chk_end) begin
                                st_nxt.t = st_r.t + 4'd1;
                            end
                        end else begin
                            st_nxt.col = st_r.col + 5'd1;
                        end
                        // resync scheduling
                        if (st_r.rsph + 6'd1 == period) begin
                            st_nxt.rsph = '0;
                            if (st_r.rscnt < rs_max) begin
                                st_nxt.rs_pend = 1'b1;
                                st_nxt.rscnt = st_r.rscnt + 6'd1;
                            end
                        end else begin
                            st_nxt.rsph = st_r.rsph + 6'd1;
                        end
                        if (nn == total) begin
                            st_nxt.fsm = ST_IDLE;
                        end
                    end
                end
            end
            default: begin
                st_nxt.fsm = ST_IDLE;
                st_nxt.ov = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r <= '0;
            st_r.fsm <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    logic acc;
    logic [5:0] hl_since;
    logic [2:0] hl_chk;
    assign acc = st_r.ov && out_ready;

    // count elements between resyncs and check bytes per sector
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hl_since <= '0;
            hl_chk <= '0;
        end else if (acc) begin
            if (st_r.elem.kind == KIND_SYNC) begin
                hl_since <= '0;
                hl_chk <= '0;
            end else if (st_r.elem.kind == KIND_RESYNC) begin
                hl_since <= '0;
            end else begin
                hl_since <= hl_since + 6'd1;
                if (st_r.elem.kind == KIND_CHECK) begin
                    hl_chk <= hl_chk + 3'd1;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_start;
        st_r.fsm == ST_IDLE ##1 st_r.fsm == ST_BODY;
    endsequence
    sequence s_sync_out;
        st_r.ov && st_r.elem.kind == KIND_SYNC;
    endsequence

    chk_sync_first: assert property (
        s_start |-> s_sync_out ##0 (st_r.ecc == '0))
        else $error("sector did not open with sync and clear ecc");
    chk_fill_value: assert property (
        st_r.ov && st_r.elem.kind == KIND_FILL |-> st_r.elem.data == 8'hff)
        else $error("fill byte not ff");
    chk_pop_order: assert property (
        fifo_pop |=> st_r.ov && st_r.elem.kind == KIND_DATA
                     && st_r.elem.data == $past(fifo_data))
        else $error("popped byte not emitted next");
    chk_stall_input: assert property (
        fifo_pop |-> st_r.fsm == ST_BODY && !st_r.rs_pend
                     && st_r.n < data_end)
        else $error("input taken outside the data part");
    chk_resync_space: assert property (
        acc && st_r.elem.kind == KIND_RESYNC |-> hl_since == period)
        else $error("resync spacing wrong");
    chk_resync_pat: assert property (
        st_r.ov && st_r.elem.kind == KIND_RESYNC |->
        ((st_r.elem.pattern & 24'hbf_fffe) == 24'h10_1020 ||
         (st_r.elem.pattern & 24'hbf_fffe) == 24'h10_1028))
        else $error("resync pattern malformed");
    chk_check_count: assert property (
        acc && st_r.elem.kind == KIND_ECC |-> hl_chk == 3'd4)
        else $error("check byte count wrong before ecc");
    chk_sector_end: assert property (
        st_r.fsm == ST_BODY && st_nxt.fsm == ST_IDLE |->
        nn == total ##1 st_r.ov && st_r.elem.kind == KIND_ECC)
        else $error("sector did not end on last ecc byte");
    chk_id_crc: assert property (
        (id_valid |=> id_crc_valid) and (!id_valid |=> !id_crc_valid))
        else $error("id check valid timing wrong");
    // the check word stands until the next identifier request
    chk_id_hold: assert property (
        !id_valid |=> $stable(id_crc))
        else $error("id check word moved without a request");
endmodule

/* File: tb/osecc_mod_sink.sv */
`timescale 1ns/1ps
// modulator stand-in: takes elements, pulls ready low at random
module osecc_mod_sink (
    input wire logic clk,
    input wire logic stall,
    input wire logic [1:0] coin,
    output logic out_ready
);
    // random back-pressure from the bench dice, moved just after the edge
    always @(posedge clk) begin
        out_ready <= #1 !(stall && coin == 2'b11);
    end
endmodule

/* File: tb/osecc_enc_test.sv */
`timescale 1ns/1ps
module osecc_enc_test;
import osecc_pkg::*;
logic clk = 0, reset_n = 0, mode_small = 0, in_valid = 0, stall = 0;
logic resync_alt = 0, chan_prev_bit = 0, chan_next_bit = 0;
logic id_valid = 0, in_ready, out_valid, out_ready, id_crc_valid;
logic [7:0] in_data = 8'h00;
logic [1:0] coin = 2'b00;
logic [23:0] id_bytes = 24'h00_0000;
logic [15:0] id_crc;
osecc_elem_t out_elem;
int n_fail = 0, n_checks = 0;
logic [31:0] lfsr_r = 32'hd58e_bac9;
osecc_elem_t eq[$];
logic [15:0] iq[$];
logic [7:0] a[1:2380];
osecc_enc i_osecc_enc (.clk(clk), .reset_n(reset_n),
    .mode_small(mode_small), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_elem(out_elem), .resync_alt(resync_alt),
    .chan_prev_bit(chan_prev_bit), .chan_next_bit(chan_next_bit),
    .id_valid(id_valid), .id_bytes(id_bytes),
    .id_crc_valid(id_crc_valid), .id_crc(id_crc));
osecc_mod_sink i_osecc_mod_sink (.clk(clk), .stall(stall), .coin(coin),
    .out_ready(out_ready));
always #10 clk = ~clk;
function automatic logic [31:0] rnd();
    lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
    return lfsr_r;
endfunction
// back-pressure dice for the modulator stand-in
always @(posedge clk) begin : dice
    logic [31:0] d;
    d = rnd();
    coin <= d[1:0];
end
function automatic logic [7:0] gmul(logic [7:0] x, logic [7:0] y);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
        if (y[i]) p ^= x;
        x = {x[6:0], 1'b0} ^ (x[7] ? 8'h2d : 8'h00);
    end
    return p;
endfunction
// monic generator from consecutive roots alpha^i = beta^(88i)
function automatic logic [16:0][7:0] mkgen(int first, int cnt);
    logic [16:0][7:0] g;
    logic [7:0] rt;
    g = '0;
    g[0] = 8'h01;
    for (int i = first; i < first + cnt; i++) begin
        rt = 8'h01;
        repeat ((88 * i) % 255) rt = gmul(rt, 8'h02);
        for (int k = 16; k > 0; k--) g[k] = g[k-1] ^ gmul(rt, g[k]);
        g[0] = gmul(rt, g[0]);
    end
    return g;
endfunction
function automatic logic [15:0][7:0] step(logic [15:0][7:0] r,
    logic [7:0] d, int deg, logic [16:0][7:0] g);
    logic [7:0] fb;
    fb = d ^ r[deg-1];
    for (int k = 15; k > 0; k--) r[k] = k < deg ? r[k-1] ^ gmul(fb, g[k]) : 0;
    r[0] = gmul(fb, g[0]);
    return r;
endfunction
task automatic check(string what, logic [23:0] e, logic [23:0] g);
    n_checks++;
    if (g !== e) begin
        n_fail++;
        $display("wrong value %s expected %h seen %h", what, e, g);
    end
endtask
task automatic cmp_elem(osecc_elem_t e);
    check("kind", e.kind, out_elem.kind);
    if (e.kind inside {KIND_DATA, KIND_FILL, KIND_CHECK, KIND_ECC})
        check("data", e.data, out_elem.data);
    if (e.kind == KIND_RESYNC) check("pattern", e.pattern, out_elem.pattern);
endtask
task automatic cmp_id(logic [15:0] e);
    check("id check", e, id_crc);
endtask
// one whole sector: expectations first, then the user bytes
task automatic sector(input logic sm);
    int tot, cols, dend, fend, cend, rows, per, m;
    logic [31:0] v;
    logic [7:0] rs[0:103];
    logic [15:0][7:0] cr, ec[20];
    logic [16:0][7:0] gc, ge;
    osecc_elem_t e;
    tot = sm ? 600 : 2380;
    cols = sm ? 5 : 20;
    dend = sm ? 512 : 2048;
    fend = sm ? 516 : 2056;
    cend = fend + 4;
    rows = sm ? 103 : 102;
    per = sm ? 20 : 60;
    cr = '0;
    gc = mkgen(136, 4);
    ge = mkgen(120, 16);
    for (int k = 0; k < 104; k++) rs[k] = 8'h00;
    for (int j = 0; j < 20; j++) ec[j] = '0;
    v = rnd();
    mode_small = sm;
    resync_alt = v[0];
    chan_prev_bit = v[1];
    chan_next_bit = v[2];
    for (int n = 1; n <= fend; n++) begin
        v = rnd();
        a[n] = n <= dend ? v[7:0] : 8'hff;
        rs[rows - (n - 1) / cols] ^= a[n];
    end
    for (int i = rows; i >= 0; i--) cr = step(cr, rs[i], 4, gc);
    for (int k = 1; k <= 4; k++) a[fend + k] = cr[4 - k];
    for (int n = 1; n <= cend; n++)
        ec[(n-1) % cols] = step(ec[(n-1) % cols], a[n], 16, ge);
    for (int n = cend + 1; n <= tot; n++) begin
        m = n - cend - 1;
        a[n] = ~ec[m % cols][15 - m / cols];
    end
    eq.push_back('{KIND_SYNC, 8'h00, 24'h00_0000});
    for (int n = 1; n <= tot; n++) begin
        e.kind = n <= dend ? KIND_DATA : n <= fend ? KIND_FILL :
            n <= cend ? KIND_CHECK : KIND_ECC;
        e.data = a[n];
        e.pattern = 24'h00_0000;
        eq.push_back(e);
        if (n % per == 0 && n < tot) begin
            e.kind = KIND_RESYNC;
            e.pattern = resync_alt ? 24'h10_1028 : 24'h10_1020;
            e.pattern[22] = ~chan_prev_bit;
            e.pattern[0] = ~chan_next_bit;
            eq.push_back(e);
        end
    end
    for (int n = 1; n <= dend; n++) begin
        v = rnd();
        if (v[3:2] == 2'b00) begin
            in_valid = 0;
            @(posedge clk) #1;
        end
        in_valid = 1;
        in_data = a[n];
        @(posedge clk);
        while (!in_ready) @(posedge clk);
        #1;
    end
    in_valid = 0;
    for (int w = 0; w < 9000 && eq.size() > 0; w++) @(posedge clk);
    #1;
    check("pending elements", 0, 24'(eq.size()));
    $display("sector test done, small mode %0d", sm);
endtask
// back-to-back identifier checks, all-zero and all-one among them
task automatic id_test();
    logic [31:0] v;
    logic [23:0] m;
    logic [15:0] r;
    for (int k = 0; k < 8; k++) begin
        v = k < 2 ? {32{k[0]}} : rnd();
        m = v[23:0] ^ 24'hff_ff00;
        r = 16'h0000;
        for (int b = 23; b >= 0; b--)
            r = {r[14:0], 1'b0} ^ ((m[b] ^ r[15]) ? 16'h1021 : 0);
        iq.push_back(r);
        id_valid = 1;
        id_bytes = v[23:0];
        @(posedge clk) #1;
    end
    id_valid = 0;
    repeat (3) @(posedge clk);
    #1;
    check("pending id checks", 0, 24'(iq.size()));
    $display("id check test done");
endtask
task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
        $display("ALL TESTS PASSED");
    end else begin
        $display("TESTS FAILED");
    end
    $finish;
endtask
// result watcher: oldest note against each accepted result
always @(posedge clk) begin
    if (reset_n && out_valid && out_ready) begin
        if (eq.size() == 0) check("surplus element", 0, 1);
        else cmp_elem(eq.pop_front());
    end
    if (reset_n && id_crc_valid) begin
        if (iq.size() == 0) check("surplus id pulse", 0, 1);
        else cmp_id(iq.pop_front());
    end
end
initial begin
    repeat (10) @(posedge clk);
    #1;
    check("reset out_valid", 0, out_valid);
    check("reset in_ready", 1, in_ready);
    reset_n = 1;
    id_test();
    stall = 1;
    sector(1);
    sector(0);
    stall = 0;
    sector(1);
    stop_test();
end
initial begin
    #400000;
    check("watchdog", 0, 1);
    stop_test();
end
endmodule
